// ===== rtl/usbes_ctrl.v
`timescale 1ns/1ns
`include "usbes_defines.vh"

// Notes on behaviour
// - codes 50h-5Fh read status byte and clear endpoint interrupt bit
// - stall (40h+) sets halted bit 7, unstall (80h+) clears it
// - SETUP token automatically unhalts a halted control endpoint
// - leaving halt flushes buffer and resets toggle to DATA0
// - bit 6 secondary buffer full, bit 5 primary buffer full
// - bit 4 holds next data toggle, 0 DATA0, 1 DATA1
// - bit 3 set on setup setup_overwritten; read clears once setup written
// - bit 2 setup present; bit 1 CPU buffer, 0 primary
// - codes 61h-6Fh set IN full flag, switch CPU buffer if double
// - OUT full after packet, NAK after; 70h,72h-7Fh clear and switch
// - codes D0h-DFh return status copy without clearing anything
// - SETUP locks control validate and clear until F4h acknowledge
// - B2h/B3h register: bit 15 DMA on, 14-13 zero, 13 scratch bits
// - F0h/F1h config: bus reset clears DMA enable, keeps others
// - config bit 15 raises end-of-transfer when counter reaches zero
// - config bit 14: short OUT packet raises end-of-transfer
// - config bits 7-4 select DMA endpoint index
// - config bit 3 starts or ends DMA; reads started; bus reset clears
// - config bits 1-0 burst: 1, 4, 8 or 16 bytes
// - F2h/F3h counter written with count, read remaining, kept at reset
// - working counter reloads from counter register on DMA re-enable
// - counter reaching zero clears config bit 3, ending DMA
// - DMA skips two length bytes, starting at third buffer byte

module usbes_ctrl (
  input wire clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire wr_n_i,
  input wire rd_n_i,
  input wire a0_i,
  input wire [7:0] data_i,
  output reg [7:0] data_o,
  output wire data_oe_o,
  input wire [15:0] ep_dir_in_i,
  input wire [15:0] ep_dbl_i,
  input wire bus_reset_i,
  input wire setup_rx_i,
  input wire setup_done_i,
  input wire pkt_done_i,
  input wire [3:0] pkt_ep_i,
  input wire short_pkt_i,
  input wire dma_byte_i,
  output reg [15:0] ep_int_clr_o,
  output wire [15:0] ep_halted_o,
  output wire [15:0] ep_toggle_o,
  output wire [15:0] ep_nak_o,
  output wire [15:0] ep_flush_o,
  output reg eot_o,
  output wire dma_active_o,
  output reg [3:0] dma_ep_o,
  output reg [4:0] dma_burst_o,
  output reg [1:0] dma_skip_o
);

// ----------------------------------------------------------------
// states of the command interpreter
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_WR = 2'b01;
localparam ST_RD = 2'b10;

// ----------------------------------------------------------------
// reset release and pin synchronisers
// ----------------------------------------------------------------
reg [1:0] rst_sync;
wire rst_n;
reg [11:0] pin_s1;
reg [11:0] pin_s2;
reg wr_d;
reg rd_d;
wire cs_s;
wire wr_s;
wire rd_s;
wire a0_s;
wire [7:0] din_s;
wire wr_strobe;
wire rd_done;

always @(posedge clk_i or negedge rst_n_i)
begin
  if (!rst_n_i)
    rst_sync <= 2'b00;
  else
    rst_sync <= {rst_sync[0], 1'b1};
end
assign rst_n = rst_sync[1];

always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    pin_s1 <= 12'hFFF;
    pin_s2 <= 12'hFFF;
    wr_d <= 1'b1;
    rd_d <= 1'b1;
  end
  else
  begin
    pin_s1 <= {cs_n_i, wr_n_i, rd_n_i, a0_i, data_i};
    pin_s2 <= pin_s1;
    wr_d <= pin_s2[10];
    rd_d <= pin_s2[9];
  end
end

assign cs_s = ~pin_s2[11];
assign wr_s = pin_s2[10];
assign rd_s = pin_s2[9];
assign a0_s = pin_s2[8];
assign din_s = pin_s2[7:0];
// write data is taken at the trailing edge of the write strobe
assign wr_strobe = cs_s & wr_s & ~wr_d;
assign rd_done = cs_s & rd_s & ~rd_d;
assign data_oe_o = cs_s & ~rd_s & ~a0_s;

// ----------------------------------------------------------------
// command decode
// ----------------------------------------------------------------
reg [1:0] state;
reg [7:0] cmd;
reg byte_idx;
reg [7:0] low_byte;
reg setup_lock;
wire cmd_wr;
wire dat_wr;
wire [3:0] grp;
wire [3:0] sel;
wire [15:0] sel_hot;
wire do_stall;
wire do_unstall;
wire do_status;
wire do_valid;
wire do_clear;
wire do_ack;

assign cmd_wr = wr_strobe & a0_s;
assign dat_wr = wr_strobe & ~a0_s;
assign grp = din_s[7:4];
assign sel = din_s[3:0];
assign sel_hot = 16'h0001 << sel;
assign do_stall = cmd_wr & (grp == `USBES_GRP_STALL);
assign do_unstall = cmd_wr & (grp == `USBES_GRP_UNSTALL);
assign do_status = cmd_wr & (grp == `USBES_GRP_STATUS);
// control endpoints refuse validate and clear while a setup is unacked
assign do_valid = cmd_wr & (grp == `USBES_GRP_VALID) & (sel != 4'h0)
                & ~(setup_lock & (sel == 4'h1));
assign do_clear = cmd_wr & (grp == `USBES_GRP_CLEAR) & (sel != 4'h1)
                & ~(setup_lock & (sel == 4'h0));
assign do_ack = cmd_wr & (din_s == `USBES_CMD_ACK);

always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
    setup_lock <= 1'b0;
  else if (setup_rx_i)
    setup_lock <= 1'b1;
  else if (do_ack)
    setup_lock <= 1'b0;
end

// ----------------------------------------------------------------
// endpoint state, one instance per endpoint
// ----------------------------------------------------------------
wire [7:0] ep_status [0:15];
wire [15:0] pkt_hot;
wire [15:0] is_in;
wire [15:0] rd_clr;

assign pkt_hot = pkt_done_i ? (16'h0001 << pkt_ep_i) : 16'h0000;
assign rd_clr = (rd_done & (state == ST_RD) & (cmd[7:4] == `USBES_GRP_STATUS))
              ? (16'h0001 << cmd[3:0]) : 16'h0000;

genvar gi;
generate
  for (gi = 0; gi < 16; gi = gi + 1)
  begin : g_ep
    assign is_in[gi] = (gi == 0) ? 1'b0 :
                       (gi == 1) ? 1'b1 : ep_dir_in_i[gi];
    usbes_ep_state u_ep (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .dbl_i((gi < 2) ? 1'b0 : ep_dbl_i[gi]),
      .is_in_i(is_in[gi]),
      .ctl_i((gi < 2) ? 1'b1 : 1'b0),
      .setup_buf_i((gi == 0) ? 1'b1 : 1'b0),
      .stall_i(do_stall & sel_hot[gi]),
      .unstall_i(do_unstall & sel_hot[gi]),
      .setup_i(setup_rx_i),
      .setup_done_i(setup_done_i),
      .ack_i(do_ack),
      .validate_i(do_valid & sel_hot[gi]),
      .clear_i(do_clear & sel_hot[gi]),
      .pkt_i(pkt_hot[gi]),
      .rd_status_i(rd_clr[gi]),
      .status_o(ep_status[gi]),
      .nak_o(ep_nak_o[gi]),
      .flush_o(ep_flush_o[gi])
    );
    assign ep_halted_o[gi] = ep_status[gi][`USBES_ST_HALT];
    assign ep_toggle_o[gi] = ep_status[gi][`USBES_ST_TOG];
  end
endgenerate

always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
    ep_int_clr_o <= 16'h0000;
  else
    ep_int_clr_o <= do_status ? sel_hot : 16'h0000;
end

// ----------------------------------------------------------------
// dma registers
// ----------------------------------------------------------------
reg [15:0] scratch;
reg [15:0] cfg;
reg [15:0] count_reg;
wire [15:0] remain;
wire cnt_zero;
wire wr_commit;
wire scr_load;
wire go_load;
wire short_end;

assign wr_commit = dat_wr & (state == ST_WR) & byte_idx;
assign dma_active_o = cfg[`USBES_CFG_GO] & scratch[`USBES_SCR_FN];
// reload whenever either enable is written to 1
assign scr_load = wr_commit & (cmd == `USBES_CMD_SCR_WR) & din_s[7];
assign go_load = wr_commit & (cmd == `USBES_CMD_CFG_WR) & low_byte[3];
assign short_end = pkt_done_i & short_pkt_i & ~is_in[pkt_ep_i]
                 & (pkt_ep_i == cfg[7:4]) & cfg[`USBES_CFG_SHORT]
                 & dma_active_o;

usbes_dma_count u_cnt (
  .clk_i(clk_i),
  .rst_n_i(rst_n),
  .load_i(scr_load | go_load),
  .load_val_i(count_reg),
  .run_i(dma_active_o),
  .byte_i(dma_byte_i),
  .count_o(remain),
  .zero_o(cnt_zero)
);

always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    scratch <= `USBES_REG_RESET;
    cfg <= `USBES_REG_RESET;
    count_reg <= `USBES_REG_RESET;
    eot_o <= 1'b0;
  end
  else
  begin
    eot_o <= (cnt_zero & cfg[`USBES_CFG_CNTEN]) | short_end;
    if (wr_commit & (cmd == `USBES_CMD_SCR_WR))
      scratch <= {din_s, low_byte} & `USBES_SCR_MASK;
    if (wr_commit & (cmd == `USBES_CMD_CNT_WR))
      count_reg <= {din_s, low_byte};
    if (wr_commit & (cmd == `USBES_CMD_CFG_WR))
      cfg <= {din_s, low_byte} & `USBES_CFG_MASK;
    else if (bus_reset_i | cnt_zero | short_end)
      cfg[`USBES_CFG_GO] <= 1'b0;
  end
end

always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    dma_ep_o <= 4'h0;
    dma_burst_o <= `USBES_BURST_1;
    dma_skip_o <= `USBES_DMA_SKIP;
  end
  else
  begin
    dma_ep_o <= cfg[`USBES_CFG_EP_HI:`USBES_CFG_EP_LO];
    dma_skip_o <= `USBES_DMA_SKIP;
    case (cfg[1:0])
      2'b00: dma_burst_o <= `USBES_BURST_1;
      2'b01: dma_burst_o <= `USBES_BURST_4;
      2'b10: dma_burst_o <= `USBES_BURST_8;
      default: dma_burst_o <= `USBES_BURST_16;
    endcase
  end
end

// ----------------------------------------------------------------
// transaction sequencing
// ----------------------------------------------------------------
always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
  begin
    state <= ST_IDLE;
    cmd <= `USBES_BYTE_RESET;
    byte_idx <= 1'b0;
    low_byte <= `USBES_BYTE_RESET;
  end
  else if (cmd_wr)
  begin
    cmd <= din_s;
    byte_idx <= 1'b0;
    // a new command always aborts an unfinished data phase
    case (din_s)
      `USBES_CMD_SCR_WR, `USBES_CMD_CFG_WR, `USBES_CMD_CNT_WR:
        state <= ST_WR;
      `USBES_CMD_SCR_RD, `USBES_CMD_CFG_RD, `USBES_CMD_CNT_RD:
        state <= ST_RD;
      default:
        if (grp == `USBES_GRP_STATUS || grp == `USBES_GRP_CHECK)
          state <= ST_RD;
        else
          state <= ST_IDLE;
    endcase
  end
  else
  begin
    case (state)
      ST_WR:
        if (dat_wr)
        begin
          low_byte <= din_s;
          byte_idx <= ~byte_idx;
          if (byte_idx)
            state <= ST_IDLE;
        end
      ST_RD:
        if (rd_done)
        begin
          byte_idx <= ~byte_idx;
          if (byte_idx | (cmd[7:4] == `USBES_GRP_STATUS)
              | (cmd[7:4] == `USBES_GRP_CHECK))
            state <= ST_IDLE;
        end
      default:
        state <= ST_IDLE;
    endcase
  end
end

// ----------------------------------------------------------------
// read data path
// ----------------------------------------------------------------
reg [15:0] rd_word;

always @*
begin
  case (cmd)
    `USBES_CMD_SCR_RD: rd_word = scratch;
    `USBES_CMD_CFG_RD: rd_word = cfg;
    `USBES_CMD_CNT_RD: rd_word = remain;
    default: rd_word = {8'h00, ep_status[cmd[3:0]]};
  endcase
end

always @(posedge clk_i or negedge rst_n)
begin
  if (!rst_n)
    data_o <= `USBES_BYTE_RESET;
  else if (state == ST_RD)
    data_o <= byte_idx ? rd_word[15:8] : rd_word[7:0];
  else
    data_o <= `USBES_BYTE_RESET;
end

endmodule

// ===== rtl/usbes_defines.vh
`ifndef USBES_DEFINES_VH
`define USBES_DEFINES_VH

// ----------------------------------------------------------------
// command codes (high nibble for per-endpoint groups)
// ----------------------------------------------------------------
`define USBES_GRP_STALL 4'h4
`define USBES_GRP_STATUS 4'h5
`define USBES_GRP_VALID 4'h6
`define USBES_GRP_CLEAR 4'h7
`define USBES_GRP_UNSTALL 4'h8
`define USBES_GRP_CHECK 4'hD
`define USBES_CMD_ACK 8'hF4
`define USBES_CMD_SCR_WR 8'hB2
`define USBES_CMD_SCR_RD 8'hB3
`define USBES_CMD_CFG_WR 8'hF0
`define USBES_CMD_CFG_RD 8'hF1
`define USBES_CMD_CNT_WR 8'hF2
`define USBES_CMD_CNT_RD 8'hF3

// ----------------------------------------------------------------
// endpoint status byte fields
// ----------------------------------------------------------------
`define USBES_ST_HALT 7
`define USBES_ST_FULL1 6
`define USBES_ST_FULL0 5
`define USBES_ST_TOG 4
`define USBES_ST_OVW 3
`define USBES_ST_SETUP 2
`define USBES_ST_CPU_BUFFER_SELECT 1

// ----------------------------------------------------------------
// dma registers
// ----------------------------------------------------------------
`define USBES_SCR_FN 15
`define USBES_SCR_MASK 16'h9FFF
`define USBES_CFG_CNTEN 15
`define USBES_CFG_SHORT 14
`define USBES_CFG_EP_HI 7
`define USBES_CFG_EP_LO 4
`define USBES_CFG_GO 3
`define USBES_CFG_MASK 16'hC0FB
`define USBES_REG_RESET 16'h0000
`define USBES_BYTE_RESET 8'h00
`define USBES_DMA_SKIP 2'h2
`define USBES_BURST_1 5'h01
`define USBES_BURST_4 5'h04
`define USBES_BURST_8 5'h08
`define USBES_BURST_16 5'h10

`endif

// ===== rtl/usbes_dma_count.v
`timescale 1ns/1ns
`include "usbes_defines.vh"

module usbes_dma_count (
  input wire clk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [15:0] load_val_i,
  input wire run_i,
  input wire byte_i,
  output reg [15:0] count_o,
  output reg zero_o
);

always @(posedge clk_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    count_o <= `USBES_REG_RESET;
    zero_o <= 1'b0;
  end
  else
  begin
    zero_o <= 1'b0;
    if (load_i)
      count_o <= load_val_i;
    else if (run_i & byte_i & (count_o != 16'h0000))
    begin
      count_o <= count_o - 16'h0001;
      zero_o <= (count_o == 16'h0001);
    end
  end
end

endmodule

// ===== rtl/usbes_ep_state.v
`timescale 1ns/1ns
`include "usbes_defines.vh"

module usbes_ep_state (
  input wire clk_i,
  input wire rst_n_i,
  input wire dbl_i,
  input wire is_in_i,
  input wire ctl_i,
  input wire setup_buf_i,
  input wire stall_i,
  input wire unstall_i,
  input wire setup_i,
  input wire setup_done_i,
  input wire ack_i,
  input wire validate_i,
  input wire clear_i,
  input wire pkt_i,
  input wire rd_status_i,
  output wire [7:0] status_o,
  output wire nak_o,
  output reg flush_o
);

reg halted;
reg [1:0] full;
reg tog;
reg ovw;
reg setup_p;
reg cpu_buf;
reg usb_buf;
reg pend;
reg writing;
reg [1:0] next_full;
reg next_cpu;
reg next_usb;
reg next_tog;
wire leave;
wire pkt_ok;
wire setup_here;

assign setup_here = setup_i & setup_buf_i;
// setup unhalts only control endpoints; unstall always re-initialises
assign leave = unstall_i | (setup_i & ctl_i & halted);
assign pkt_ok = pkt_i & ~halted & (is_in_i ? full[usb_buf] : ~full[usb_buf]);
assign nak_o = ~is_in_i & full[usb_buf];
assign status_o = {halted, full[1], full[0], tog, ovw, setup_p,
                   cpu_buf, 1'b0};

always @*
begin
  next_full = full;
  next_cpu = cpu_buf;
  next_usb = usb_buf;
  next_tog = tog;
  if (validate_i | clear_i)
  begin
    next_full[cpu_buf] = validate_i;
    if (dbl_i)
      next_cpu = ~cpu_buf;
  end
  if (pkt_ok)
  begin
    next_full[usb_buf] = ~is_in_i;
    next_tog = ~tog;
    if (dbl_i)
      next_usb = ~usb_buf;
  end
  if (leave)
  begin
    next_full = 2'b00;
    next_cpu = 1'b0;
    next_usb = 1'b0;
    next_tog = 1'b0;
  end
  if (setup_here)
    next_full[0] = 1'b1;
end

always @(posedge clk_i or negedge rst_n_i)
begin
  if (!rst_n_i)
  begin
    halted <= 1'b0;
    full <= 2'b00;
    tog <= 1'b0;
    ovw <= 1'b0;
    setup_p <= 1'b0;
    cpu_buf <= 1'b0;
    usb_buf <= 1'b0;
    pend <= 1'b0;
    writing <= 1'b0;
    flush_o <= 1'b0;
  end
  else
  begin
    full <= next_full;
    cpu_buf <= next_cpu;
    usb_buf <= next_usb;
    tog <= next_tog;
    flush_o <= leave;
    if (stall_i)
      halted <= 1'b1;
    else if (leave)
      halted <= 1'b0;
    if (setup_here)
      setup_p <= 1'b1;
    else if (clear_i)
      setup_p <= 1'b0;
    // set wins over the read-clear
    if (setup_here & pend)
      ovw <= 1'b1;
    else if (rd_status_i & ~writing)
      ovw <= 1'b0;
    if (setup_here)
      pend <= 1'b1;
    else if (ack_i | stall_i)
      pend <= 1'b0;
    if (setup_here)
      writing <= 1'b1;
    else if (setup_done_i)
      writing <= 1'b0;
  end
end

endmodule

// ===== test/usbes_ctrl_asserts.sv
`timescale 1ns/1ns
// ------
// port checker
// ------
module usbes_ctrl_chk (
  input wire clk_i,
  input wire rst_n_i,
  input wire rd_n_i,
  input wire setup_rx_i,
  input wire [15:0] ep_dir_in_i,
  input wire data_oe_o,
  input wire [15:0] ep_int_clr_o,
  input wire [15:0] ep_halted_o,
  input wire [15:0] ep_toggle_o,
  input wire [15:0] ep_nak_o,
  input wire [15:0] ep_flush_o,
  input wire eot_o,
  input wire dma_active_o,
  input wire [4:0] dma_burst_o,
  input wire [1:0] dma_skip_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence ctl_free;
    ep_halted_o[1:0] == 2'b00;
  endsequence
  sequence end_hit;
    eot_o;
  endsequence
  chk_skip_two: assert property (dma_skip_o == 2'h2)
    else $error("dma skip not two");
  chk_burst_legal: assert property (dma_burst_o inside
    {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("burst size illegal");
  chk_end_pulse: assert property (end_hit |=> !eot_o)
    else $error("end pulse too long");
  chk_end_cause: assert property (end_hit |->
    $past(dma_active_o) || $past(dma_active_o, 2))
    else $error("end without running dma");
  chk_end_stops: assert property (end_hit |=> !dma_active_o)
    else $error("dma still running after end");
  chk_clr_onehot: assert property ($onehot0(ep_int_clr_o))
    else $error("several interrupt clears");
  chk_clr_pulse: assert property (ep_int_clr_o != 16'h0000
    |=> ep_int_clr_o == 16'h0000)
    else $error("interrupt clear too long");
  chk_flush_toggle: assert property (ep_flush_o != 16'h0000
    |=> (ep_toggle_o & $past(ep_flush_o)) == 16'h0000)
    else $error("flushed endpoint kept toggle");
  chk_setup_unhalt: assert property (setup_rx_i
    |-> ##[1:6] ctl_free)
    else $error("control endpoint still halted");
  chk_nak_out_only: assert property ((ep_nak_o & 16'hFFFE
    & (ep_dir_in_i | 16'h0002)) == 16'h0000)
    else $error("nak on in endpoint");
  chk_oe_read: assert property (data_oe_o |-> !$past(rd_n_i, 2)
    || !$past(rd_n_i, 3) || !$past(rd_n_i, 4))
    else $error("bus driven without read");
endmodule
bind usbes_ctrl usbes_ctrl_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .rd_n_i(rd_n_i), .setup_rx_i(setup_rx_i), .ep_dir_in_i(ep_dir_in_i),
  .data_oe_o(data_oe_o), .ep_int_clr_o(ep_int_clr_o),
  .ep_halted_o(ep_halted_o), .ep_toggle_o(ep_toggle_o),
  .ep_nak_o(ep_nak_o), .ep_flush_o(ep_flush_o), .eot_o(eot_o),
  .dma_active_o(dma_active_o), .dma_burst_o(dma_burst_o),
  .dma_skip_o(dma_skip_o));

// ===== test/usbes_ctrl_test.sv
`timescale 1ns/1ns
module usbes_ctrl_test;
  logic clk_i, rst_n_i, cs_n, wr_n, rd_n, a0, short_pkt_i, ok;
  logic [7:0] din, dout, b;
  logic [4:0] ev;
  logic [3:0] pkt_ep_i, dma_ep_o;
  logic [4:0] dma_burst_o;
  logic [15:0] ep_dir_in_i, ep_dbl_i, clr, halt, nak, last_clr, w, n, cfg;
  logic eot_o, dma_active_o, oe;
  logic [15:0] tog, fl, last_fl;
  logic [7:0] st [16];
  logic [4:0] bl [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
  logic [31:0] lf = 32'hC484;
  int bad_count = 0, num_checks = 0, clrs = 0, ends = 0, c0, e0, oes = 0;
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  usbes_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .a0_i(a0), .data_i(din),
    .data_o(dout), .data_oe_o(oe), .ep_dir_in_i(ep_dir_in_i),
    .ep_dbl_i(ep_dbl_i), .bus_reset_i(ev[4]), .setup_rx_i(ev[0]),
    .setup_done_i(ev[1]), .pkt_done_i(ev[2]), .pkt_ep_i(pkt_ep_i),
    .short_pkt_i(short_pkt_i), .dma_byte_i(ev[3]), .ep_int_clr_o(clr),
    .ep_halted_o(halt), .ep_toggle_o(tog), .ep_nak_o(nak),
    .ep_flush_o(fl), .eot_o(eot_o), .dma_active_o(dma_active_o),
    .dma_ep_o(dma_ep_o), .dma_burst_o(dma_burst_o), .dma_skip_o());
  usbes_mcu m (.clk_i(clk_i), .rdat_i(dout), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .a0_o(a0), .dat_o(din));
  always @(posedge clk_i)
  begin
    if (clr !== 16'h0000)
    begin
      clrs++;
      last_clr = clr;
    end
    if (eot_o === 1'b1)
      ends++;
    if (fl !== 16'h0000)
      last_fl = fl;
    if (oe === 1'b1)
      oes++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string s, input logic [15:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic hit(input logic [4:0] v);
    @(negedge clk_i);
    ev = v;
    @(negedge clk_i);
    ev = 5'h00;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    ev = 5'h00;
    pkt_ep_i = 4'h0;
    short_pkt_i = 1'b0;
    ep_dir_in_i = 16'h0022;
    ep_dbl_i = 16'h0010;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge clk_i);
    for (int e = 0; e < 16; e++)
    begin
      m.cmd(8'h40 | 8'(e));
      st[e] = 8'h80;
      chk("halted", 16'h0001 << e, halt);
      c0 = clrs;
      m.rd8(8'h50 | 8'(e), b);
      chk("status", st[e], b);
      chk("clear bit", 16'h0001 << e, last_clr);
      m.unstall(4'(e));
      chk("flush", 16'h0001 << e, last_fl);
      st[e] = 8'h00;
      m.rd8(8'hD0 | 8'(e), b);
      chk("image", st[e], b);
      chk("no clear", c0 + 1, clrs);
      chk("unhalted", 16'h0000, halt);
    end
    m.cmd(8'h40);
    m.cmd(8'h41);
    hit(5'h01);
    chk("setup unhalt", 16'h0000, halt);
    chk("setup flush", 16'h0003, last_fl);
    hit(5'h02);
    e0 = oes;
    m.rd8(8'hD0, b);
    chk("setup status", 8'h24, b & 8'hEF);
    chk("read drive", 1'b1, oes > e0);
    chk("drive off", 1'b0, oe);
    m.cmd(8'h61);
    m.rd8(8'hD1, b);
    chk("locked", 8'h00, b & 8'hEF);
    m.ack(ok);
    m.cmd(8'h61);
    m.rd8(8'hD1, b);
    chk("validated", 8'h20, b & 8'hEF);
    hit(5'h01);
    hit(5'h01);
    hit(5'h02);
    m.rd8(8'h50, b);
    chk("overwritten", 8'h2C, b & 8'hEF);
    m.rd8(8'h50, b);
    chk("setup_overwritten gone", 8'h24, b & 8'hEF);
    pkt_ep_i = 4'h3;
    hit(5'h04);
    chk("nak", 1'b1, nak[3]);
    m.rd8(8'hD3, b);
    chk("out full", 1'b1, b[5]);
    m.cmd(8'h73);
    chk("nak off", 1'b0, nak[3]);
    pkt_ep_i = 4'h4;
    hit(5'h04);
    m.cmd(8'h74);
    m.rd8(8'hD4, b);
    chk("cpu buffer", 1'b1, b[1]);
    m.cmd(8'h65);
    m.rd8(8'hD5, b);
    chk("in full", 8'h20, b);
    pkt_ep_i = 4'h5;
    hit(5'h04);
    m.rd8(8'hD5, b);
    chk("toggle", 8'h10, b);
    chk("toggle pin", 1'b1, tog[5]);
    lf = lfsr(lf);
    m.wr16(8'hB2, lf[15:0]);
    m.rd16(8'hB3, w);
    chk("scratch", lf[15:0] & 16'h9FFF, w);
    m.wr16(8'hB2, 16'h8000);
    for (int k = 0; k < 4; k++)
    begin
      lf = lfsr(lf);
      n = {14'h0000, lf[1:0]} + 16'h0002;
      cfg = {8'h80, lf[7:4], 2'b10, 2'(k)};
      m.wr16(8'hF2, n);
      m.wr16(8'hF0, cfg);
      chk("active", 1'b1, dma_active_o);
      chk("dma ep", lf[7:4], dma_ep_o);
      chk("burst", bl[k], dma_burst_o);
      hit(5'h08);
      m.rd16(8'hF3, w);
      chk("remaining", n - 16'h0001, w);
      e0 = ends;
      repeat (n - 1) hit(5'h08);
      chk("end", e0 + 1, ends);
      chk("stopped", 1'b0, dma_active_o);
      m.rd16(8'hF1, w);
      chk("cfg", cfg & 16'hFFF7, w);
    end
    m.wr16(8'hF0, cfg);
    hit(5'h10);
    m.rd16(8'hF1, w);
    chk("reset cfg", cfg & 16'hFFF7, w);
    m.rd16(8'hF3, w);
    chk("reset count", n, w);
    m.wr16(8'hF0, 16'h4068);
    e0 = ends;
    pkt_ep_i = 4'h6;
    short_pkt_i = 1'b1;
    hit(5'h04);
    short_pkt_i = 1'b0;
    chk("short end", e0 + 1, ends);
    chk("short stop", 1'b0, dma_active_o);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
endmodule

// ===== test/usbes_mcu.sv
`timescale 1ns/1ns
// ------
// microcontroller on the command bus
// ------
module usbes_mcu (
  input wire clk_i,
  input wire [7:0] rdat_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic a0_o,
  output logic [7:0] dat_o
);
  initial
  begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    a0_o = 1'b1;
    dat_o = 8'hA5;
  end
  // write strobe held four clocks, read strobe six, so the two pin flops see them
  task automatic wr(input logic cmd, input logic [7:0] v);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    a0_o = cmd;
    dat_o = v;
    wr_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    wr_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
    dat_o = ~v;
  endtask
  task automatic rd(output logic [7:0] v);
    @(negedge clk_i);
    a0_o = 1'b0;
    rd_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    v = rdat_i;
    rd_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(1'b1, c);
  endtask
  task automatic rd8(input logic [7:0] c, output logic [7:0] v);
    wr(1'b1, c);
    rd(v);
  endtask
  task automatic wr16(input logic [7:0] c, input logic [15:0] v);
    wr(1'b1, c);
    wr(1'b0, v[7:0]);
    wr(1'b0, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] c, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    wr(1'b1, c);
    rd(lo);
    rd(hi);
    v = {hi, lo};
  endtask
  task automatic unstall(input logic [3:0] e);
    cmd({4'h8, e});
    cmd({4'h8, e});
  endtask
  // overwritten setup is left unacknowledged and ok returns low
  task automatic ack(output logic ok);
    logic [7:0] s;
    rd8(8'hD0, s);
    ok = !s[3];
    if (ok)
      cmd(8'hF4);
  endtask
endmodule
